// *** core/iof_defs.svh ***
// Register map, field positions, reset values, code bytes and timing counts of the image port formatter
`ifndef IOF_DEFS_SVH
`define IOF_DEFS_SVH
`define IOF_ADDR_PIN      8'h84
`define IOF_ADDR_CFG      8'h85
`define IOF_ADDR_FIFO     8'h86
`define IOF_ADDR_CLK      8'h87
`define IOF_ADDR_FMT      8'h93
`define IOF_RST_VAL       8'h00
`define IOF_CFG_W16       0
`define IOF_CFG_GCLK      1
`define IOF_CFG_NOCODE    2
`define IOF_CFG_TXTSAV    3
`define IOF_CFG_QINV      4
`define IOF_CFG_LIMIT     5
`define IOF_CFG_AINV      6
`define IOF_CFG_BINV      7
`define IOF_FIFO_AE_LSB   0
`define IOF_FIFO_AF_LSB   2
`define IOF_FIFO_ARB_LSB  6
`define IOF_CLK_SEL_LSB   0
`define IOF_CLK_TMSB      2
`define IOF_CLK_RINV      3
`define IOF_FMT_FSI_LSB   0
`define IOF_FMT_FOI_LSB   3
`define IOF_FMT_LUMA_LINE_SKIP_CTRL      5
`define IOF_FSI_422       3'h0
`define IOF_FSI_411       3'h1
`define IOF_FSI_420       3'h2
`define IOF_FSI_410       3'h3
`define IOF_ARB_OFF       2'h0
`define IOF_ARB_BLANK     2'h1
`define IOF_ARB_TEXT      2'h3
`define IOF_FIFO_DEPTH    6'd32
`define IOF_FIFO_W        36
`define IOF_TAG_SOL       32
`define IOF_TAG_EOL       33
`define IOF_TAG_FID       34
`define IOF_TAG_VACT      35
`define IOF_AF_TABLE      24'h81c610
`define IOF_AE_TABLE      24'h004210
`define IOF_LIM0_LO       8'h01
`define IOF_LIM0_HI       8'hfe
`define IOF_LIM1_LO       8'h08
`define IOF_LIM1_HI       8'hf7
`define IOF_NODATA        8'h00
`define IOF_PREAMBLE      24'h0000ff
`define IOF_ANC_PRE       24'hffff00
`define IOF_ANC_ID        8'h00
`define IOF_CODES_M0      64'h7f3862255413490e
`define IOF_CODES_M1      64'hf1b6ecabda9dc780
`define IOF_INT_HALF      4'd4
`endif

// *** core/iof_fifo.sv ***
// Video FIFO of 32 tagged Dwords with programmable fill flags
`timescale 1ns/100ps
`include "iof_defs.svh"
module iof_fifo (
	// Clock and reset
	input wire logic   sys_clk,
	input wire logic   rstn,
	// Both sides and flags
	iof_fifo_if.fifo   f
);
	logic [`IOF_FIFO_W-1:0] mem [0:31];
	logic [4:0]             wp_r;
	logic [4:0]             rp_r;
	logic [5:0]             lvl_r;
	logic                   fcf_r;
	logic                   fifo_overflow_flag_r;
	logic                   full;
	logic                   push;
	logic                   pull;
	logic [5:0]             af_lvl;
	logic [5:0]             ae_lvl;

	function automatic logic [5:0] pick_lvl(input logic [23:0] tbl, input logic [1:0] sel);
		case (sel)
			2'h0: return tbl[5:0];
			2'h1: return tbl[11:6];
			2'h2: return tbl[17:12];
			default: return tbl[23:18];
		endcase
	endfunction

	assign full   = lvl_r == `IOF_FIFO_DEPTH;
	assign push   = f.wr_en && !full;
	assign pull   = f.rd_pop && lvl_r != 6'd0;
	assign af_lvl = pick_lvl(`IOF_AF_TABLE, f.af_sel);
	assign ae_lvl = pick_lvl(`IOF_AE_TABLE, f.ae_sel);

	always_ff @(posedge sys_clk) begin
		if (push) begin
			mem[wp_r] <= f.wr_data;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			wp_r  <= 5'h00;
			rp_r  <= 5'h00;
			lvl_r <= 6'h00;
		end else begin
			wp_r  <= wp_r + {4'h0, push};
			rp_r  <= rp_r + {4'h0, pull};
			lvl_r <= lvl_r + {5'h00, push} - {5'h00, pull};
		end
	end

	// Filled flag with hysteresis; overflow sticky, set wins over clear
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			fcf_r  <= 1'b0;
			fifo_overflow_flag_r <= 1'b0;
		end else begin
			if (f.faf) begin
				fcf_r <= 1'b1;
			end else if (lvl_r < ae_lvl || lvl_r == 6'h00) begin
				fcf_r <= 1'b0;
			end
			if (f.wr_en && full) begin
				fifo_overflow_flag_r <= 1'b1;
			end else if (f.ovl_clr) begin
				fifo_overflow_flag_r <= 1'b0;
			end
		end
	end

	assign f.rd_valid = lvl_r != 6'h00;
	assign f.rd_data  = mem[rp_r];
	assign f.fae      = lvl_r <= ae_lvl;
	assign f.faf      = lvl_r >= af_lvl;
	assign f.fcf      = fcf_r;
	assign f.fifo_overflow_flag     = fifo_overflow_flag_r;
endmodule

// *** core/iof_fifo_if.sv ***
// Connection between the packer, the output sequencer and the video FIFO
`timescale 1ns/100ps
interface iof_fifo_if;
	logic        wr_en;
	logic [35:0] wr_data;
	logic        rd_pop;
	logic        rd_valid;
	logic [35:0] rd_data;
	logic [1:0]  af_sel;
	logic [1:0]  ae_sel;
	logic        ovl_clr;
	logic        fae;
	logic        fcf;
	logic        faf;
	logic        fifo_overflow_flag;
	modport user (output wr_en, wr_data, rd_pop, af_sel, ae_sel, ovl_clr,
		input rd_valid, rd_data, fae, fcf, faf, fifo_overflow_flag);
	modport fifo (input wr_en, wr_data, rd_pop, af_sel, ae_sel, ovl_clr,
		output rd_valid, rd_data, fae, fcf, faf, fifo_overflow_flag);
endinterface

// *** core/iof_image_port.sv ***
// Image port output formatter: packer, video FIFO, text arbitration, serializer and reference pins
// Functional notes
// - Output stream is 8 or 16 bits wide with reference and timing signals.
// - Port clock chosen among internal, decoder, expansion or external clock, to 33 MHz.
// - Cycles without valid data carry 00 on all data pins, upper byte too.
// - Stream is marked by a data qualifier or a gated clock.
// - Two arbitration bits at 86H govern sharing of video and sliced text.
// - Internal Dwords are serialized into bytes or 16-bit words.
// - Start/end codes frame video; text gets ancillary header or start/end codes.
// - Events are routable to pins through 84H and 85H.
// - Packing 4:2:2, 4:1:1, 4:2:0, 4:1:0, luma only, set at 93H.
// - Luma line count sets luma-only lines before each combined line.
// - With skip control 0, leading luma-only lines are dropped.
// - Output is whole Dwords; no planar formats.
// - 8-bit byte orders for 4:2:2, 4:1:1 and luma only as listed.
// - Luma samples numbered 0 to 719, chroma on even pixels 0 to 718.
// - Limit bit 0 clips to 01..FE, 1 clips to 08..F7.
// - Video FIFO holds 32 Dwords.
// - Port runs on the source clock or on a controller-supplied clock.
// - FIFO reports almost empty, filled, almost full and overflow.
// - Filled flag sets at almost full, clears below almost empty.
// - Almost full 16/24/28/full, almost empty 16/8/4/empty, at 86H.
// - FIFO flags observable on either general pin via the pin mapping.
// - Text inserted after a video line when FIFO holds no pixels.
// - Each start/end code is preceded by FF, 00, 00.
// - Qualifier and reference outputs active high, each invertible.
`timescale 1ns/100ps
`include "iof_defs.svh"
module iof_image_port (
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rstn,
	// Subaddress register port
	input  wire logic [7:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	output logic      [7:0]  reg_rdata,
	// Scaled video samples
	input  wire logic        vid_valid,
	input  wire logic [7:0]  vid_y,
	input  wire logic [7:0]  vid_c,
	input  wire logic        vid_sol,
	input  wire logic        vid_eol,
	input  wire logic        vid_fid,
	input  wire logic        vid_vact,
	input  wire logic        vid_field_start,
	input  wire logic        programming_page_toggle,
	// Sliced text Dwords
	input  wire logic        txt_req,
	input  wire logic        txt_valid,
	input  wire logic [31:0] txt_data,
	input  wire logic        txt_last,
	output logic             txt_ready,
	// Port clock pins
	input  wire logic        dec_clk_pin,
	input  wire logic        exp_clk_pin,
	input  wire logic        ext_clk_pin,
	// Image port outputs
	output logic      [7:0]  port_data,
	output logic      [7:0]  upper_output_data_pins,
	output logic             output_data_qualifier,
	output logic             port_href,
	output logic             port_vref,
	output logic             port_general_pin_a,
	output logic             port_general_pin_b
);
	// ============================================================
	// Registers
	logic [7:0] pin_map_r;
	logic [7:0] cfg_r;
	logic [7:0] fifo_cfg_r;
	logic [7:0] clk_cfg_r;
	logic [7:0] fmt_r;
	logic [7:0] rdata_r;
	logic [1:0] arb;
	logic [2:0] horizontal_packing_select;
	logic [1:0] luma_line_count;
	logic       w16;
	logic       no_code;
	iof_fifo_if ff ();

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			pin_map_r  <= `IOF_RST_VAL;
			cfg_r      <= `IOF_RST_VAL;
			fifo_cfg_r <= `IOF_RST_VAL;
			clk_cfg_r  <= `IOF_RST_VAL;
			fmt_r      <= `IOF_RST_VAL;
		end else if (reg_wr) begin
			case (reg_addr)
				`IOF_ADDR_PIN:  pin_map_r <= reg_wdata;
				`IOF_ADDR_CFG:  cfg_r <= reg_wdata;
				`IOF_ADDR_FIFO: fifo_cfg_r <= reg_wdata;
				`IOF_ADDR_CLK:  clk_cfg_r <= {4'h0, reg_wdata[3:0]};
				`IOF_ADDR_FMT:  fmt_r <= {2'b00, reg_wdata[5:0]};
				default: ;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			rdata_r <= 8'h00;
		end else begin
			case (reg_addr)
				`IOF_ADDR_PIN:  rdata_r <= pin_map_r;
				`IOF_ADDR_CFG:  rdata_r <= cfg_r;
				`IOF_ADDR_FIFO: rdata_r <= fifo_cfg_r;
				`IOF_ADDR_CLK:  rdata_r <= {ff.fifo_overflow_flag, ff.faf, ff.fcf, ff.fae, clk_cfg_r[3:0]};
				`IOF_ADDR_FMT:  rdata_r <= fmt_r;
				default:        rdata_r <= 8'h00;
			endcase
		end
	end

	assign reg_rdata  = rdata_r;
	assign arb        = fifo_cfg_r[`IOF_FIFO_ARB_LSB +: 2];
	assign horizontal_packing_select        = fmt_r[`IOF_FMT_FSI_LSB +: 3];
	assign luma_line_count        = fmt_r[`IOF_FMT_FOI_LSB +: 2];
	assign w16        = cfg_r[`IOF_CFG_W16];
	assign no_code    = cfg_r[`IOF_CFG_NOCODE];
	assign ff.af_sel  = fifo_cfg_r[`IOF_FIFO_AF_LSB +: 2];
	assign ff.ae_sel  = fifo_cfg_r[`IOF_FIFO_AE_LSB +: 2];
	assign ff.ovl_clr = reg_wr && reg_addr == `IOF_ADDR_FIFO;

	// ============================================================
	// Packer
	logic [9:0]  px_r;
	logic [9:0]  px;
	logic [2:0]  k;
	logic [1:0]  phase_r;
	logic        yc_seen_r;
	logic        line_yc_r;
	logic        line_drop_r;
	logic        first_r;
	logic [7:0]  ybuf [0:7];
	logic [7:0]  cprev_r;
	logic [7:0]  ly;
	logic [7:0]  lc;
	logic        sub_mode;
	logic        pk411;
	logic        yc_calc;
	logic        cur_yc;
	logic        cur_drop;
	logic        wr_pt;
	logic        vid_wr;
	iof_pkg::iof_word_t word;

	iof_limit u_limit (
		.narrow (cfg_r[`IOF_CFG_LIMIT]),
		.y_in   (vid_y),
		.c_in   (vid_c),
		.y_out  (ly),
		.c_out  (lc)
	);

	assign sub_mode = horizontal_packing_select == `IOF_FSI_420 || horizontal_packing_select == `IOF_FSI_410;
	assign pk411    = horizontal_packing_select == `IOF_FSI_411 || horizontal_packing_select == `IOF_FSI_410;

	always_comb begin
		px       = vid_sol ? 10'h000 : px_r;
		k        = px[2:0];
		yc_calc  = sub_mode ? phase_r == luma_line_count : (horizontal_packing_select == `IOF_FSI_422 || horizontal_packing_select == `IOF_FSI_411);
		cur_yc   = vid_sol ? yc_calc : line_yc_r;
		cur_drop = vid_sol ? sub_mode && !fmt_r[`IOF_FMT_LUMA_LINE_SKIP_CTRL] && !yc_seen_r && !yc_calc : line_drop_r;
		wr_pt    = 1'b0;
		word     = 32'h0000_0000;
		if (!cur_yc) begin
			wr_pt = k[1:0] == 2'h3;
			word  = {ly, ybuf[{k[2], 2'h2}], ybuf[{k[2], 2'h1}], ybuf[{k[2], 2'h0}]};
		end else if (!pk411) begin
			wr_pt = k[0];
			word  = {ly, lc, ybuf[{k[2:1], 1'b0}], cprev_r};
		end else begin
			wr_pt = k == 3'h1 || k == 3'h5 || k == 3'h7;
			case (k)
				3'h5: word = {ybuf[3], lc, ybuf[2], cprev_r};
				3'h7: word = {ly, ybuf[6], ybuf[5], ybuf[4]};
				default: word = {ly, lc, ybuf[0], cprev_r};
			endcase
		end
		// Whole Dwords only; a line end flushes the Dword in progress
		vid_wr = vid_valid && !cur_drop && arb != `IOF_ARB_TEXT && (wr_pt || vid_eol);
	end

	assign ff.wr_en   = vid_wr;
	assign ff.wr_data = {vid_vact, vid_fid, vid_eol, vid_sol | first_r, word};

	always_ff @(posedge sys_clk) begin
		if (vid_valid) begin
			ybuf[k] <= ly;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			px_r        <= 10'h000;
			line_yc_r   <= 1'b0;
			line_drop_r <= 1'b0;
			first_r     <= 1'b0;
			cprev_r     <= 8'h00;
		end else if (vid_valid) begin
			px_r    <= px + 10'h001;
			cprev_r <= lc;
			first_r <= vid_wr ? 1'b0 : (vid_sol | first_r);
			if (vid_sol) begin
				line_yc_r   <= yc_calc;
				line_drop_r <= cur_drop;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn || vid_field_start) begin
			phase_r   <= 2'h0;
			yc_seen_r <= 1'b0;
		end else if (vid_valid && vid_eol) begin
			phase_r <= (phase_r == luma_line_count || !sub_mode) ? 2'h0 : phase_r + 2'h1;
			if (cur_yc) begin
				yc_seen_r <= 1'b1;
			end
		end
	end

	iof_fifo u_fifo (
		.sys_clk (sys_clk),
		.rstn    (rstn),
		.f       (ff.fifo)
	);

	// ============================================================
	// Port clock selection and edge finding
	logic [2:0] pin_s1_r;
	logic [2:0] pin_s2_r;
	logic [3:0] div_r;
	logic       int_lvl_r;
	logic       pclk_lvl;
	logic       pclk_prev_r;
	logic       pclk_en;

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			pin_s1_r    <= 3'h0;
			pin_s2_r    <= 3'h0;
			pclk_prev_r <= 1'b0;
			div_r       <= 4'h0;
			int_lvl_r   <= 1'b0;
		end else begin
			pin_s1_r    <= {ext_clk_pin, exp_clk_pin, dec_clk_pin};
			pin_s2_r    <= pin_s1_r;
			pclk_prev_r <= pclk_lvl;
			div_r       <= (div_r == `IOF_INT_HALF - 4'd1) ? 4'h0 : div_r + 4'h1;
			if (div_r == `IOF_INT_HALF - 4'd1) begin
				int_lvl_r <= !int_lvl_r;
			end
		end
	end

	always_comb begin
		case (clk_cfg_r[`IOF_CLK_SEL_LSB +: 2])
			2'h0: pclk_lvl = int_lvl_r;
			2'h1: pclk_lvl = pin_s2_r[0];
			2'h2: pclk_lvl = pin_s2_r[1];
			default: pclk_lvl = pin_s2_r[2];
		endcase
	end

	assign pclk_en = pclk_lvl && !pclk_prev_r;

	// ============================================================
	// Output sequencer and arbitration
	iof_pkg::iof_state_e st_r;
	iof_pkg::iof_state_e st_nxt;
	iof_pkg::iof_word_t  sh_r;
	iof_pkg::iof_word_t  ld_word;
	logic [2:0] cnt_r;
	logic       ld;
	logic       txt_ok;
	logic       txt_msb;
	logic       vid_msb;
	logic       line_fid_r;
	logic       line_vact_r;

	function automatic logic [7:0] itu_code(input logic msb, input logic blank, input logic eav,
		input logic fid);
		logic [63:0] tbl;
		tbl = msb ? `IOF_CODES_M1 : `IOF_CODES_M0;
		return tbl[{blank, eav, fid, 3'b000} +: 8];
	endfunction

	assign txt_msb = clk_cfg_r[`IOF_CLK_TMSB];
	assign vid_msb = !programming_page_toggle;
	assign txt_ok  = txt_req && arb != `IOF_ARB_OFF && (arb != `IOF_ARB_BLANK || !ff.rd_valid);

	always_comb begin
		st_nxt    = st_r;
		ld        = 1'b0;
		ld_word   = 32'h0000_0000;
		ff.rd_pop = 1'b0;
		txt_ready = 1'b0;
		if (cnt_r == 3'h0) begin
			case (st_r)
				iof_pkg::ST_IDLE: begin
					if (ff.rd_valid && ff.rd_data[`IOF_TAG_SOL] && arb != `IOF_ARB_TEXT) begin
						ld      = !no_code;
						ld_word = {itu_code(vid_msb, !ff.rd_data[`IOF_TAG_VACT], 1'b0,
							ff.rd_data[`IOF_TAG_FID]), `IOF_PREAMBLE};
						st_nxt  = iof_pkg::ST_VDATA;
					end else if (txt_ok) begin
						ld      = !no_code;
						ld_word = cfg_r[`IOF_CFG_TXTSAV] ?
							{itu_code(txt_msb, 1'b1, 1'b0, vid_fid), `IOF_PREAMBLE} :
							{`IOF_ANC_ID, `IOF_ANC_PRE};
						st_nxt  = iof_pkg::ST_TDATA;
					end else if (ff.rd_valid) begin
						ff.rd_pop = 1'b1;
					end
				end
				iof_pkg::ST_VDATA: begin
					if (ff.rd_valid) begin
						ff.rd_pop = 1'b1;
						ld        = 1'b1;
						ld_word   = ff.rd_data[31:0];
						if (ff.rd_data[`IOF_TAG_EOL]) begin
							st_nxt = no_code ? iof_pkg::ST_IDLE : iof_pkg::ST_VEAV;
						end
					end
				end
				iof_pkg::ST_VEAV: begin
					ld      = 1'b1;
					ld_word = {itu_code(vid_msb, !line_vact_r, 1'b1, line_fid_r), `IOF_PREAMBLE};
					st_nxt  = iof_pkg::ST_IDLE;
				end
				iof_pkg::ST_TDATA: begin
					if (txt_valid) begin
						txt_ready = 1'b1;
						ld        = 1'b1;
						ld_word   = txt_data;
						if (txt_last) begin
							st_nxt = (cfg_r[`IOF_CFG_TXTSAV] && !no_code) ? iof_pkg::ST_TEAV : iof_pkg::ST_IDLE;
						end
					end
				end
				iof_pkg::ST_TEAV: begin
					ld      = 1'b1;
					ld_word = {itu_code(txt_msb, 1'b1, 1'b1, vid_fid), `IOF_PREAMBLE};
					st_nxt  = iof_pkg::ST_IDLE;
				end
				default: st_nxt = iof_pkg::ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			st_r  <= iof_pkg::ST_IDLE;
			sh_r  <= 32'h0000_0000;
			cnt_r <= 3'h0;
		end else begin
			st_r <= st_nxt;
			if (ld) begin
				sh_r  <= ld_word;
				cnt_r <= 3'h4;
			end else if (pclk_en && cnt_r != 3'h0) begin
				sh_r  <= w16 ? {16'h0000, sh_r[31:16]} : {8'h00, sh_r[31:8]};
				cnt_r <= (w16 && cnt_r > 3'h1) ? cnt_r - 3'h2 : cnt_r - 3'h1;
			end
		end
	end

	// ============================================================
	// Data pins, qualifier and reference signals
	logic [7:0] data_r;
	logic [7:0] upper_r;
	logic       qual_r;
	logic       gclk_r;
	logic       href_r;
	logic       vref_r;
	logic       hstart_r;
	logic       vstart_r;
	logic       marker_r;
	logic       pin_a_r;
	logic       pin_b_r;
	logic [15:0] ev;

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			data_r  <= `IOF_NODATA;
			upper_r <= `IOF_NODATA;
			qual_r  <= 1'b0;
			gclk_r  <= 1'b0;
		end else begin
			gclk_r <= pclk_lvl && qual_r;
			if (pclk_en) begin
				qual_r  <= cnt_r != 3'h0;
				data_r  <= cnt_r != 3'h0 ? sh_r[7:0] : `IOF_NODATA;
				upper_r <= (cnt_r != 3'h0 && w16) ? sh_r[15:8] : `IOF_NODATA;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			href_r      <= 1'b0;
			vref_r      <= 1'b0;
			hstart_r    <= 1'b0;
			vstart_r    <= 1'b0;
			marker_r    <= 1'b0;
			line_fid_r  <= 1'b0;
			line_vact_r <= 1'b0;
		end else begin
			hstart_r <= 1'b0;
			vstart_r <= 1'b0;
			if (st_r == iof_pkg::ST_IDLE && st_nxt == iof_pkg::ST_VDATA) begin
				line_fid_r  <= ff.rd_data[`IOF_TAG_FID];
				line_vact_r <= ff.rd_data[`IOF_TAG_VACT];
				vref_r      <= ff.rd_data[`IOF_TAG_VACT];
				vstart_r    <= ff.rd_data[`IOF_TAG_VACT] && !vref_r;
				href_r      <= 1'b1;
				hstart_r    <= 1'b1;
				marker_r    <= 1'b0;
			end else if (st_r == iof_pkg::ST_IDLE && st_nxt == iof_pkg::ST_TDATA) begin
				marker_r <= 1'b1;
			end else if (st_r != iof_pkg::ST_IDLE && st_nxt == iof_pkg::ST_IDLE && !marker_r) begin
				href_r <= 1'b0;
			end
		end
	end

	assign ev = {2'b00, vstart_r, hstart_r, marker_r, ff.fifo_overflow_flag, ff.faf, ff.fcf, ff.fae,
		programming_page_toggle, gclk_r, qual_r, href_r, vref_r, line_fid_r, 1'b0};

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			pin_a_r <= 1'b0;
			pin_b_r <= 1'b0;
		end else begin
			pin_a_r <= ev[pin_map_r[3:0]] ^ cfg_r[`IOF_CFG_AINV];
			pin_b_r <= ev[pin_map_r[7:4]] ^ cfg_r[`IOF_CFG_BINV];
		end
	end

	assign port_data              = data_r;
	assign upper_output_data_pins = upper_r;
	assign output_data_qualifier  = (cfg_r[`IOF_CFG_GCLK] ? gclk_r : qual_r) ^ cfg_r[`IOF_CFG_QINV];
	assign port_href              = href_r ^ clk_cfg_r[`IOF_CLK_RINV];
	assign port_vref              = vref_r ^ clk_cfg_r[`IOF_CLK_RINV];
	assign port_general_pin_a     = pin_a_r;
	assign port_general_pin_b     = pin_b_r;
endmodule

// *** core/iof_limit.sv ***
// Amplitude limiter for one luma and one chroma sample
`timescale 1ns/100ps
`include "iof_defs.svh"
module iof_limit (
	// Range select
	input  wire logic       narrow,
	// Samples
	input  wire logic [7:0] y_in,
	input  wire logic [7:0] c_in,
	output logic      [7:0] y_out,
	output logic      [7:0] c_out
);
	function automatic logic [7:0] clip(input logic [7:0] v, input logic nar);
		logic [7:0] lo;
		logic [7:0] hi;
		lo = nar ? `IOF_LIM1_LO : `IOF_LIM0_LO;
		hi = nar ? `IOF_LIM1_HI : `IOF_LIM0_HI;
		if (v < lo) return lo;
		if (v > hi) return hi;
		return v;
	endfunction

	assign y_out = clip(y_in, narrow);
	assign c_out = clip(c_in, narrow);
endmodule

// *** core/iof_pkg.sv ***
// Types shared by the image port formatter modules
package iof_pkg;
	typedef enum logic [4:0] {
		ST_IDLE  = 5'b00001,
		ST_VDATA = 5'b00010,
		ST_VEAV  = 5'b00100,
		ST_TDATA = 5'b01000,
		ST_TEAV  = 5'b10000
	} iof_state_e;
	typedef logic [31:0] iof_word_t;
endpackage

// *** sim/iof_capture_model.sv ***
// Capture controller model: free running port clock and qualified byte capture
`timescale 1ns/100ps
module iof_capture_model (
	// Clock
	input wire logic       sys_clk,
	// Image port
	input wire logic [7:0] port_data,
	input wire logic       output_data_qualifier,
	output logic           ext_clk_pin
);
	logic [2:0] phase_r;
	logic [7:0] cap_q[$];
	initial begin
		phase_r = 3'h0;
		ext_clk_pin = 1'b0;
	end
	// 400 ns external clock; bytes of the previous edge are taken at each rising edge
	always @(posedge sys_clk) begin
		phase_r <= phase_r + 3'h1;
		ext_clk_pin <= phase_r < 3'h4;
		if (phase_r == 3'h0 && output_data_qualifier === 1'b1)
			cap_q.push_back(port_data);
	end
endmodule

// *** sim/iof_image_port_props.sv ***
// Port checker of the image port formatter
`timescale 1ns/100ps
module iof_image_port_props (
	// Clock, reset and registers
	input wire logic       sys_clk,
	input wire logic       rstn,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_wr,
	input wire logic [7:0] reg_rdata,
	// Text, port clock and outputs
	input wire logic       txt_ready,
	input wire logic       ext_clk_pin,
	input wire logic [7:0] port_data,
	input wire logic [7:0] upper_output_data_pins,
	input wire logic       output_data_qualifier,
	input wire logic       port_general_pin_a,
	input wire logic       port_general_pin_b
);
	logic [7:0] c84_r, c85_r, c86_r, c87_r;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	// ==========================================
	// Mirror of the written configuration
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			c84_r <= 8'h00;
			c85_r <= 8'h00;
			c86_r <= 8'h00;
			c87_r <= 8'h00;
		end else if (reg_wr) begin
			if (reg_addr == 8'h84) c84_r <= reg_wdata;
			if (reg_addr == 8'h85) c85_r <= reg_wdata;
			if (reg_addr == 8'h86) c86_r <= reg_wdata;
			if (reg_addr == 8'h87) c87_r <= reg_wdata;
		end
	end
	// ==========================================
	// Assertions
	chk_reset_quiet: assert property (disable iff (1'b0) !rstn |=> port_data == 8'h00
		&& !output_data_qualifier && reg_rdata == 8'h00) else $error("outputs not cleared by reset");
	chk_idle_zero: assert property (!c85_r[1] && !c85_r[4] && !output_data_qualifier |->
		port_data == 8'h00 && upper_output_data_pins == 8'h00) else $error("idle cycle not 00");
	chk_upper_byte: assert property (!c85_r[0] |-> upper_output_data_pins == 8'h00)
		else $error("upper byte driven in 8-bit mode");
	chk_reg_readback: assert property (reg_wr && reg_addr == 8'h93 ##1 (!reg_wr && reg_addr == 8'h93) [*2]
		|-> reg_rdata == $past(reg_wdata, 2)) else $error("format register readback wrong");
	chk_port_edge: assert property (c87_r[1:0] == 2'h3 && $changed(port_data) |->
		$past(ext_clk_pin, 2) && !$past(ext_clk_pin, 5)) else $error("data moved off port clock edge");
	chk_pin_a_level: assert property ((c84_r[3:0] == 4'h0 && !c85_r[6]) [*3] |-> !port_general_pin_a)
		else $error("pin a not at event level");
	chk_pin_b_inv: assert property ((c84_r[7:4] == 4'h0 && c85_r[7]) [*3] |-> port_general_pin_b)
		else $error("pin b not inverted");
	chk_text_off: assert property (c86_r[7:6] == 2'h0 |-> !txt_ready) else $error("text taken while off");
	cov_qual: cover property ($rose(output_data_qualifier));
	cov_fifo_cfg: cover property (reg_wr && reg_addr == 8'h86);
	cov_overflow: cover property (reg_addr == 8'h87 && reg_rdata[7]);
endmodule
bind iof_image_port iof_image_port_props chk_u (.*);

// *** sim/testbench.sv ***
// Self-checking bench of the image port formatter
`timescale 1ns/100ps
module testbench;
	logic        sys_clk, rstn, reg_wr, vid_valid, vid_sol, vid_eol, vid_fid, vid_vact, vid_field_start;
	logic        programming_page_toggle, txt_req, txt_valid, txt_last, txt_ready, dec_clk_pin, exp_clk_pin;
	logic        ext_clk_pin, output_data_qualifier, port_href, port_vref, port_general_pin_a, port_general_pin_b;
	logic [7:0]  reg_addr, reg_wdata, reg_rdata, vid_y, vid_c, port_data, upper_output_data_pins, v, r;
	logic [31:0] txt_data;
	logic [63:0] cw;
	logic [7:0]  pix_y[80], pix_c[80];
	int          miscompares, check_count, seed, k, f, nb;
	iof_image_port dut_u (.*);
	iof_capture_model partner_u (.*);
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) {exp_clk_pin, dec_clk_pin} <= {exp_clk_pin, dec_clk_pin} + 2'h1;
	// ==========================================
	// Comparison, register access and closing
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		repeat (2) @(posedge sys_clk);
		#1 d = reg_rdata;
	endtask
	task automatic conclude();
		$display("checks %0d miscompares %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// ==========================================
	// Expected stream
	function automatic logic [7:0] lim(input logic [7:0] x, input logic n);
		if (n)
			return x < 8'h08 ? 8'h08 : (x > 8'hf7 ? 8'hf7 : x);
		return x == 8'h00 ? 8'h01 : (x == 8'hff ? 8'hfe : x);
	endfunction
	function automatic logic [7:0] exp_byte(input int f, input int k, input logic n);
		int cb = (f == 1) ? 4 * (k / 4) : 2 * (k / 4);
		int yb = 2 * (k / 4);
		if (f == 4 || (f == 1 && k > 7))
			return lim(pix_y[f == 4 ? k : k - 4], n);
		return lim((k % 2) ? pix_y[yb + k % 4 / 2] : pix_c[cb + k % 4 / 2], n);
	endfunction
	// ==========================================
	// Video line and capture wait
	task automatic send_line(input int n, input logic fid);
		@(posedge sys_clk);
		vid_field_start <= 1'b1;
		@(posedge sys_clk);
		vid_field_start <= 1'b0;
		for (int i = 0; i < n; i++) begin
			@(posedge sys_clk);
			vid_valid <= 1'b1;
			vid_y <= pix_y[i];
			vid_c <= pix_c[i];
			vid_sol <= i == 0;
			vid_eol <= i == n - 1;
			vid_fid <= fid;
			txt_data <= $random(seed);
		end
		@(posedge sys_clk);
		vid_valid <= 1'b0;
	endtask
	task automatic wait_cap(input int n);
		for (k = 0; k < 4000 && partner_u.cap_q.size() < n; k++)
			@(posedge sys_clk);
		if (k == 4000) begin
			miscompares++;
			$display("timeout waiting for port bytes");
			conclude();
		end
	endtask
	// ==========================================
	// Main sequence
	initial begin
		seed = 28;
		{rstn, reg_wr, vid_valid, vid_sol, vid_eol, vid_fid, vid_field_start, dec_clk_pin, exp_clk_pin} = '0;
		{programming_page_toggle, txt_req, txt_valid, txt_last} = '0;
		vid_vact = 1'b1;
		{reg_addr, reg_wdata, vid_y, vid_c} = '0;
		txt_data = '0;
		miscompares = 0;
		check_count = 0;
		repeat (5) @(posedge sys_clk);
		rstn <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			rd(i == 3 ? 8'h93 : 8'h84 + i[7:0], v);
			check("reset value", v, 8'h00);
		end
		v = $random(seed);
		wr(8'h84, v);
		wr(8'h88, 8'hff);
		rd(8'h84, r);
		check("pin map", r, v);
		wr(8'h84, 8'h00);
		wr(8'h87, 8'hf3);
		rd(8'h87, v);
		check("empty status", v, 8'h13);
		$display("test registers done");
		for (int m = 0; m < 6; m++) begin
			f = m % 3 == 2 ? 4 : m % 3;
			wr(8'h85, {2'h2, m >= 3, 5'h00});
			wr(8'h93, f[7:0]);
			rd(8'h93, v);
			check("format", v, f[7:0]);
			for (int i = 0; i < 8; i++) {pix_y[i], pix_c[i]} = $random(seed);
			pix_y[0] = m >= 3 ? 8'h05 : 8'h00;
			pix_c[1] = 8'hff;
			pix_y[3] = 8'hf9;
			send_line(8, m[0]);
			nb = f == 0 ? 16 : (f == 1 ? 12 : 8);
			cw = {m[0] ? 8'hda : 8'h9d, 16'h0000, 8'hff, m[0] ? 8'hc7 : 8'h80, 16'h0000, 8'hff};
			wait_cap(nb + 8);
			for (int i = 0; i < nb + 8; i++)
				check("port byte", partner_u.cap_q[i], (i < 4 || i >= nb + 4) ? cw[8 * (i < 4 ? i : i - nb) +: 8]
					: exp_byte(f, i - 4, m >= 3));
			partner_u.cap_q.delete();
			$display("test format %0d limit %0d done", f, m / 3);
		end
		wr(8'h86, 8'hc0);
		{txt_req, txt_valid, txt_last} <= 3'h7;
		@(posedge sys_clk);
		txt_req <= 1'b0;
		cw = {txt_data, 32'h00ffff00};
		wait_cap(8);
		for (int i = 0; i < 8; i++) check("text byte", partner_u.cap_q[i], cw[8 * i +: 8]);
		partner_u.cap_q.delete();
		$display("test text done");
		wr(8'h93, 8'h00);
		wr(8'h86, 8'h0a);
		for (int i = 0; i < 80; i++) {pix_y[i], pix_c[i]} = $random(seed);
		send_line(80, 1'b0);
		rd(8'h87, v);
		check("full status", v, 8'he3);
		wr(8'h86, 8'h0a);
		rd(8'h87, v);
		check("overflow cleared", v, 8'h63);
		for (k = 0; k < 3000 && v[6] !== 1'b0; k++) rd(8'h87, v);
		check("filled holds", v, 8'h23);
		for (k = 0; k < 3000 && v !== 8'h13; k++) rd(8'h87, v);
		check("drained status", v, 8'h13);
		$display("test fifo flags done");
		conclude();
	end
endmodule
